/* design/bbx_exec.sv */
// execution unit for relative branches and the file bit-set instruction
// assumes fetch presents one instruction word per instruction cycle,
// held stable from q1 through q4, and memory read data valid in q3
module bbx_exec (
  input  wire logic                          i_clk,
  input  wire logic                          i_reset,
  input  bbx_pkg::bbx_insn_s                 i_insn,
  input  wire logic [bbx_pkg::PC_W-1:0]      i_pc,
  input  wire logic                          i_zero,
  input  wire logic                          i_overflow,
  input  wire logic [3:0]                    i_bank_select_value,
  input  wire logic [bbx_pkg::DATA_W-1:0]    i_rd_data,
  output logic                               o_rd_en,
  output logic [bbx_pkg::ADDR_W-1:0]         o_rd_addr,
  output bbx_pkg::bbx_mem_s                  o_wr,
  output logic                               o_pc_load,
  output logic [bbx_pkg::PC_W-1:0]           o_pc_target,
  output logic                               o_flush,
  output logic [3:0]                         o_quarter
);
  import bbx_pkg::*;

  // ==========================================================
  // quarter phases
  bbx_quarter_e quarter;

  bbx_quarter_gen u_quarter (
    .i_clk     (i_clk),
    .i_reset   (i_reset),
    .o_quarter (quarter)
  );

  // ==========================================================
  // decode
  logic              is_branch_not_zero;
  logic              is_branch_not_ovf;
  logic              is_branch_always;
  logic              is_set_file_bit;
  logic              take;
  logic [PC_W-1:0]   ofs_ext;
  logic [ADDR_W-1:0] file_addr;

  always_comb begin
    is_branch_not_zero = i_insn.valid &&
      (i_insn.word[15:8] == OPC_BRANCH_NOT_ZERO);
    is_branch_not_ovf  = i_insn.valid &&
      (i_insn.word[15:8] == OPC_BRANCH_NOT_OVF);
    is_branch_always   = i_insn.valid &&
      (i_insn.word[15:11] == OPC_BRANCH_ALWAYS);
    is_set_file_bit    = i_insn.valid &&
      (i_insn.word[15:12] == OPC_SET_FILE_BIT);
    take = (is_branch_not_zero && !i_zero) ||
           (is_branch_not_ovf && !i_overflow) || is_branch_always;
    if (is_branch_always) begin
      ofs_ext = PC_W'(signed'(i_insn.word[LONG_OFS_MSB:0]));
    end else begin
      ofs_ext = PC_W'(signed'(i_insn.word[SHORT_OFS_MSB:0]));
    end
    if (i_insn.word[ACCESS_POS]) begin
      file_addr = {i_bank_select_value, i_insn.word[FILE_ADDR_MSB:0]};
    end else if (i_insn.word[FILE_ADDR_MSB:0] >= ACCESS_SPLIT) begin
      file_addr = {ACCESS_HIGH_BANK, i_insn.word[FILE_ADDR_MSB:0]};
    end else begin
      file_addr = {ACCESS_LOW_BANK, i_insn.word[FILE_ADDR_MSB:0]};
    end
  end

  // ==========================================================
  // branch group: offset latch, target, pc load, nop slot
  logic            nop_cycle;
  logic            next_nop_cycle;
  logic [PC_W-1:0] ofs_lit;
  logic [PC_W-1:0] next_ofs_lit;
  logic [PC_W-1:0] target;
  logic [PC_W-1:0] next_target;
  logic            next_pc_load;
  logic [PC_W-1:0] next_pc_target;
  logic            next_flush;

  always_comb begin
    next_nop_cycle = nop_cycle;
    next_ofs_lit   = ofs_lit;
    next_target    = target;
    next_pc_load   = 1'b0;
    next_pc_target = o_pc_target;
    next_flush     = 1'b0;
    // the instruction slot after a taken branch is forced to nothing
    if (nop_cycle) begin
      if (quarter == Q4) begin
        next_nop_cycle = 1'b0;
      end
    end else begin
      case (quarter)
        Q1: begin
          // decode only
        end
        Q2: begin
          next_ofs_lit = ofs_ext;
        end
        Q3: begin
          // carry beyond width dropped
          // a whole clock for the adder ahead of the q4 load
          next_target = i_pc + PC_STEP + (ofs_lit << 1);
        end
        Q4: begin
          // taken costs a second cycle
          // flags are read only here, at the last quarter
          if (take) begin
            next_pc_load   = 1'b1;
            next_pc_target = target;
            next_flush     = 1'b1;
            next_nop_cycle = 1'b1;
          end
        end
        default: begin
          next_nop_cycle = 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // bit-set group: read, modify, write back
  logic [DATA_W-1:0] mod_data;
  logic [DATA_W-1:0] next_mod_data;
  logic              next_rd_en;
  logic [ADDR_W-1:0] next_rd_addr;
  bbx_mem_s          next_wr;
  logic [DATA_W-1:0] bit_mask;

  always_comb begin
    next_mod_data = mod_data;
    next_rd_en    = 1'b0;
    next_rd_addr  = o_rd_addr;
    next_wr       = '0;
    bit_mask      = DATA_W'(1) << i_insn.word[BIT_MSB:BIT_LSB];
    // memory is left alone in the slot after a taken branch
    if (is_set_file_bit && !nop_cycle) begin
      case (quarter)
        Q1: begin
          // decode only
        end
        Q2: begin
          next_rd_en   = 1'b1;
          next_rd_addr = file_addr;
        end
        Q3: begin
          // force bit to one
          // read data must be settled in q3, no wait states
          next_mod_data = i_rd_data | bit_mask;
        end
        Q4: begin
          // write back in q4
          // reuse the read address, bank select may change mid-cycle
          next_wr.en   = 1'b1;
          next_wr.addr = o_rd_addr;
          next_wr.data = mod_data;
        end
        default: begin
          next_wr = '0;
        end
      endcase
    end
  end

  // ==========================================================
  // registers
  // flags are never driven here, so all four instructions leave them intact
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      nop_cycle   <= 1'b0;
      ofs_lit     <= '0;
      target      <= PC_RESET;
      o_pc_load   <= 1'b0;
      o_pc_target <= PC_RESET;
      o_flush     <= 1'b0;
    end else begin
      nop_cycle   <= next_nop_cycle;
      ofs_lit     <= next_ofs_lit;
      target      <= next_target;
      o_pc_load   <= next_pc_load;
      o_pc_target <= next_pc_target;
      o_flush     <= next_flush;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mod_data  <= '0;
      o_rd_en   <= 1'b0;
      o_rd_addr <= '0;
      o_wr      <= '0;
    end else begin
      mod_data  <= next_mod_data;
      o_rd_en   <= next_rd_en;
      o_rd_addr <= next_rd_addr;
      o_wr      <= next_wr;
    end
  end

  // quarter echo, one clock behind the internal phase
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_quarter <= Q1;
    end else begin
      o_quarter <= quarter;
    end
  end

endmodule

/* design/bbx_pkg.sv */
// package for the branch and bit-set execution block
// assumes a single 10 MHz core clock with four quarter phases per cycle
package bbx_pkg;

  // ==========================================================
  // widths
  localparam int PC_W   = 21;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 12;
  localparam int INSN_W = 16;

  // ==========================================================
  // opcode encodings
  localparam logic [7:0] OPC_BRANCH_NOT_ZERO = 8'hE1;
  localparam logic [7:0] OPC_BRANCH_NOT_OVF  = 8'hE5;
  localparam logic [4:0] OPC_BRANCH_ALWAYS   = 5'h1A;
  localparam logic [3:0] OPC_SET_FILE_BIT    = 4'h8;

  // ==========================================================
  // instruction field positions
  localparam int SHORT_OFS_MSB = 7;
  localparam int LONG_OFS_MSB  = 10;
  localparam int FILE_ADDR_MSB = 7;
  localparam int ACCESS_POS    = 8;
  localparam int BIT_LSB       = 9;
  localparam int BIT_MSB       = 11;

  // access bank split: low half of bank 0, high half of top bank
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;
  localparam logic [3:0] ACCESS_LOW_BANK  = 4'h0;

  // ==========================================================
  // reset values and step
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;
  localparam logic [PC_W-1:0] PC_STEP  = 21'h000002;
  localparam logic [1:0]      Q_FIRST  = 2'h0;

  // ==========================================================
  // carrier types
  typedef struct packed {
    logic             valid;
    logic [INSN_W-1:0] word;
  } bbx_insn_s;

  typedef struct packed {
    logic              en;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } bbx_mem_s;

  typedef enum logic [3:0] {
    Q1 = 4'b0001,
    Q2 = 4'b0010,
    Q3 = 4'b0100,
    Q4 = 4'b1000
  } bbx_quarter_e;

endpackage

/* design/bbx_quarter_gen.sv */
// quarter phase generator: one-hot q1..q4 enables per instruction cycle
// assumes synchronous active-high reset on the core clock
module bbx_quarter_gen (
  input  wire logic                  i_clk,
  input  wire logic                  i_reset,
  output bbx_pkg::bbx_quarter_e      o_quarter
);
  import bbx_pkg::*;

  bbx_quarter_e quarter;
  bbx_quarter_e next_quarter;

  always_comb begin
    case (quarter)
      Q1:      next_quarter = Q2;
      Q2:      next_quarter = Q3;
      Q3:      next_quarter = Q4;
      Q4:      next_quarter = Q1;
      default: next_quarter = Q1;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      quarter <= Q1;
    end else begin
      quarter <= next_quarter;
    end
  end

  assign o_quarter = quarter;

endmodule

/* verification/bbx_exec_sva.sv */
// checker for the branch and bit-set execution block
// assumes it is bound onto bbx_exec, one clock, sync reset
module bbx_exec_sva (
  input wire logic          i_clk,
  input wire logic          i_reset,
  input bbx_pkg::bbx_insn_s i_insn,
  input wire logic [3:0]    i_bank_select_value,
  input wire logic [7:0]    i_rd_data,
  input wire logic          o_rd_en,
  input wire logic [11:0]   o_rd_addr,
  input bbx_pkg::bbx_mem_s  o_wr,
  input wire logic          o_pc_load,
  input wire logic          o_flush,
  input wire logic [3:0]    o_quarter
);
  import bbx_pkg::*;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_reset);
  // ==========================================================
  // properties
  property p_flush; o_flush == o_pc_load; endproperty
  a_flush: assert property (p_flush) else $error("flush");
  property p_gap; o_pc_load |=> !o_pc_load [*7]; endproperty
  a_gap: assert property (p_gap) else $error("load gap");
  property p_nop; o_pc_load |=> !o_rd_en [*3] ##1 !o_wr.en; endproperty
  a_nop: assert property (p_nop) else $error("nop cycle");
  property p_rmw; o_rd_en |-> ##2 o_wr.en; endproperty
  a_rmw: assert property (p_rmw) else $error("rmw order");
  property p_wadr;
    o_wr.en |-> o_wr.addr == o_rd_addr && $past(o_rd_en, 2);
  endproperty
  a_wadr: assert property (p_wadr) else $error("wr addr");
  property p_wdat;
    o_wr.en |-> o_wr.data ==
      ($past(i_rd_data, 2) | (8'h01 << $past(i_insn.word[11:9], 2)));
  endproperty
  a_wdat: assert property (p_wdat) else $error("wr data");
  property p_bank;
    o_rd_en |-> o_rd_addr == {i_insn.word[8] ? i_bank_select_value :
      (i_insn.word[7] ? 4'hF : 4'h0), i_insn.word[7:0]};
  endproperty
  a_bank: assert property (p_bank) else $error("bank");
  property p_rdp; o_rd_en |=> !o_rd_en [*3]; endproperty
  a_rdp: assert property (p_rdp) else $error("rd pulse");
  property p_q; $onehot(o_quarter); endproperty
  a_q: assert property (p_q) else $error("quarter");
  c_load: cover property (o_pc_load);
  c_rmw: cover property (o_rd_en ##2 o_wr.en);
  c_wr: cover property (o_wr.en);
endmodule
bind bbx_exec bbx_exec_sva i_sva (.i_clk(i_clk), .i_reset(i_reset),
  .i_insn(i_insn), .i_bank_select_value(i_bank_select_value),
  .i_rd_data(i_rd_data), .o_rd_en(o_rd_en), .o_rd_addr(o_rd_addr),
  .o_wr(o_wr), .o_pc_load(o_pc_load), .o_flush(o_flush),
  .o_quarter(o_quarter));

/* verification/tb_bbx_exec.sv */
// bench for the branch and bit-set execution block
// assumes the checker is bound from bbx_exec_sva.sv
module tb_bbx_exec;
  timeunit 1ns;
  timeprecision 1ns;
  import bbx_pkg::*;
  logic i_clk, i_reset, i_zero, i_overflow, o_rd_en, o_pc_load, o_flush;
  logic [3:0] i_bank_select_value, o_quarter;
  logic [7:0] i_rd_data;
  logic [11:0] o_rd_addr;
  logic [20:0] i_pc, o_pc_target;
  bbx_insn_s i_insn;
  bbx_mem_s o_wr;
  int fails, num_checks, ld, fl, rd, wr;
  bbx_exec i_dut (.i_clk(i_clk), .i_reset(i_reset), .i_insn(i_insn),
    .i_pc(i_pc), .i_zero(i_zero), .i_overflow(i_overflow),
    .i_bank_select_value(i_bank_select_value), .i_rd_data(i_rd_data),
    .o_rd_en(o_rd_en), .o_rd_addr(o_rd_addr), .o_wr(o_wr),
    .o_pc_load(o_pc_load), .o_pc_target(o_pc_target),
    .o_flush(o_flush), .o_quarter(o_quarter));
  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [20:0] t8(logic [20:0] pc, logic [7:0] n);
    return pc + 21'h2 + {{12{n[7]}}, n, 1'b0};
  endfunction
  function automatic logic [20:0] t11(logic [20:0] pc, logic [10:0] n);
    return pc + 21'h2 + {{9{n[10]}}, n, 1'b0};
  endfunction
  // one instruction, then a filler that is valid only when the branch is taken, which must drop it
  task automatic run(input logic [15:0] w, input logic [20:0] pc,
    input logic z, v, input logic [7:0] d, input logic e_ld,
    input logic [20:0] e_t);
    logic e_wr;
    logic q_bad;
    logic [11:0] wa;
    logic [7:0] wd;
    e_wr = (w[15:12] == OPC_SET_FILE_BIT);
    q_bad = 1'b0;
    wa = '0;
    wd = '0;
    ld = 9; fl = 9; rd = 9; wr = 9;
    i_insn <= '{1'b1, w};
    i_pc <= pc;
    i_zero <= z;
    i_overflow <= v;
    i_rd_data <= d;
    for (int i = 0; i < 7; i++) begin
      @(posedge i_clk);
      if (i == 3) i_insn <= '{e_ld, {OPC_SET_FILE_BIT, 12'h0}};
      #1;
      if (o_quarter !== (4'h1 << (i % 4))) q_bad = 1'b1;
      if (o_pc_load === 1'b1) ld = (ld == 9) ? i : 8;
      if (o_flush === 1'b1) fl = (fl == 9) ? i : 8;
      if (o_rd_en === 1'b1) rd = (rd == 9) ? i : 8;
      if (o_wr.en === 1'b1) begin
        wr = (wr == 9) ? i : 8;
        wa = o_wr.addr;
        wd = o_wr.data;
      end
    end
    chk(21'(ld), e_ld ? 21'h3 : 21'h9);
    chk(21'(fl), e_ld ? 21'h3 : 21'h9);
    chk(21'(rd), e_wr ? 21'h1 : 21'h9);
    chk(21'(wr), e_wr ? 21'h3 : 21'h9);
    chk(21'(q_bad), 21'h0);
    if (e_ld) chk(o_pc_target, e_t);
    if (e_wr) begin
      chk(21'(wa), 21'({w[8] ? 4'h5 : (w[7] ? 4'hF : 4'h0),
        w[7:0]}));
      chk(21'(wd), 21'(d | (8'h01 << w[11:9])));
    end
    @(posedge i_clk);
  endtask
  task automatic t_branch();
    run({OPC_BRANCH_NOT_ZERO, 8'h80}, 21'h100, 1'b0, 1'b1, 8'h0, 1'b1,
      t8(21'h100, 8'h80));
    run({OPC_BRANCH_NOT_ZERO, 8'h7F}, 21'h100, 1'b1, 1'b0, 8'h0, 1'b0,
      21'h0);
    run({OPC_BRANCH_NOT_OVF, 8'h7F}, 21'h1FFFFE, 1'b1, 1'b0, 8'h0, 1'b1,
      t8(21'h1FFFFE, 8'h7F));
    run({OPC_BRANCH_NOT_OVF, 8'h01}, 21'h40, 1'b0, 1'b1, 8'h0, 1'b0,
      21'h0);
    run({OPC_BRANCH_ALWAYS, 11'h400}, 21'h10, 1'b1, 1'b1, 8'h0, 1'b1,
      t11(21'h10, 11'h400));
    run({OPC_BRANCH_ALWAYS, 11'h3FF}, 21'h1FFF00, 1'b1, 1'b1, 8'h0,
      1'b1, t11(21'h1FFF00, 11'h3FF));
    $display("branch test done");
  endtask
  // rotates through low access, high access and banked addressing
  task automatic t_bits();
    logic [7:0] f;
    for (int b = 0; b < 8; b++) begin
      f = (b % 3 == 1) ? 8'hA0 + 8'(b) : 8'h20 + 8'(b);
      run({OPC_SET_FILE_BIT, 3'(b), b % 3 == 2, f}, 21'h0, 1'b0, 1'b0,
        b[0] ? ~(8'h01 << b) : 8'h0A, 1'b0, 21'h0);
    end
    $display("bit set test done");
  endtask
  task automatic tally_and_finish();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  initial begin
    #200000;
    fails++;
    tally_and_finish();
  end
  initial begin
    i_reset = 1'b1;
    i_insn = '0;
    i_pc = '0;
    i_zero = 1'b0;
    i_overflow = 1'b0;
    i_rd_data = 8'h00;
    i_bank_select_value = 4'h5;
    repeat (4) @(posedge i_clk);
    i_reset <= 1'b0;
    t_branch();
    t_bits();
    tally_and_finish();
  end
endmodule
